/* inc/host_port_pkg.sv */
// Constants and types for the multiplexed bus host port
package host_port_pkg;

    // ----------------------------------------------------------------
    // Bus and register layout
    // ----------------------------------------------------------------
    localparam int BUS_WIDTH = 8;
    localparam int NIBBLE_WIDTH = 4;
    localparam int UNIT_COUNT_MAX = 15;
    localparam logic [7:0] MAP_FULL_ADDR = 8'hFF;
    localparam logic [3:0] MAP_REG_INDEX = 4'hF;
    localparam logic [3:0] PORTZ_CTRL_INDEX = 4'h7;
    localparam int PORTZ_IRQ_MODE_BIT = 7;
    localparam logic [7:0] PORTZ_CTRL_RESET = 8'h00;
    localparam logic [3:0] BASE_RESET = 4'h0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // Bit i set: register i may be read / written
    localparam logic [15:0] READABLE_MASK = 16'h7FFF;
    localparam logic [15:0] WRITABLE_MASK = 16'hF7FF;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic address_latch_strobe;
        logic data_strobe;
        logic read_select;
    } host_ctrl_type;

    typedef struct packed {
        logic [3:0] index;
        logic write_pulse;
        logic [7:0] write_data;
    } reg_request_type;

endpackage

/* rtl/reg_access_filter.sv */
// Readable and writable decode of one register index
`timescale 1ns/1ps
module reg_access_filter #(
    parameter logic [15:0] READ_MASK = host_port_pkg::READABLE_MASK,
    parameter logic [15:0] WRITE_MASK = host_port_pkg::WRITABLE_MASK
) (
    input wire logic [3:0] index,
    output logic readable,
    output logic writable
);

    // ----------------------------------------------------------------
    // Table lookup
    // ----------------------------------------------------------------
    assign readable = READ_MASK[index];
    assign writable = WRITE_MASK[index];

endmodule

/* rtl/muxed_bus_host_port.sv */
// Host-side multiplexed address/data port with mapping register and reset chain
`timescale 1ns/1ps
module muxed_bus_host_port #(
    parameter int IRQ_COUNT = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire host_port_pkg::host_ctrl_type host_ctrl,
    input wire logic [7:0] muxed_addr_data_bus_in,
    output logic [7:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe_n,
    input wire logic chain_reset_in,
    output logic chain_reset_out,
    input wire logic [IRQ_COUNT-1:0] irq_flag,
    input wire logic [IRQ_COUNT-1:0] irq_enable_bit,
    input wire logic portz_bit7_out,
    input wire logic portz_bit7_oe_n,
    output logic irq_or_portz_bit7_pin_out,
    output logic irq_or_portz_bit7_pin_oe_n,
    output logic irq_request_n,
    output logic [7:0] portz_control,
    output logic [3:0] base_nibble,
    output logic mapped,
    output host_port_pkg::reg_request_type reg_request,
    input wire logic [7:0] reg_read_data
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic strobe_prev_reg;
    logic strobe_prev_next;
    logic [3:0] base_reg;
    logic [3:0] base_next;
    logic mapped_reg;
    logic mapped_next;
    logic chain_out_reg;
    logic chain_out_next;
    logic [7:0] portz_ctrl_reg;
    logic [7:0] portz_ctrl_next;
    logic [7:0] bus_out_reg;
    logic [7:0] bus_out_next;
    logic bus_oe_n_reg;
    logic bus_oe_n_next;
    logic irq_n_reg;
    logic irq_n_next;
    logic pin_out_reg;
    logic pin_out_next;
    logic pin_oe_n_reg;
    logic pin_oe_n_next;
    host_port_pkg::reg_request_type request_reg;
    host_port_pkg::reg_request_type request_next;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic selected;
    logic write_edge;
    logic read_active;
    logic readable;
    logic writable;
    logic irq_pending;

    reg_access_filter access_filter (
        .index(addr_reg[3:0]),
        .readable(readable),
        .writable(writable)
    );

    // Unmapped units only answer at the full mapping address, and only the
    // first unit whose chain input is released does so: that keeps the
    // chain walking one unit at a time.
    always_comb begin
        if (mapped_reg) begin
            selected = (addr_reg[7:4] == base_reg);
        end else begin
            selected = (addr_reg == host_port_pkg::MAP_FULL_ADDR) && chain_reset_in;
        end
    end

    // Write taken on the rising edge of the data strobe
    assign write_edge = host_ctrl.data_strobe && !strobe_prev_reg
        && !host_ctrl.read_select && selected;
    assign read_active = host_ctrl.data_strobe && host_ctrl.read_select
        && selected && readable;
    assign irq_pending = |(irq_flag & irq_enable_bit);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        addr_next = addr_reg;
        strobe_prev_next = host_ctrl.data_strobe;
        base_next = base_reg;
        mapped_next = mapped_reg;
        portz_ctrl_next = portz_ctrl_reg;
        bus_out_next = host_port_pkg::DATA_ZERO;
        bus_oe_n_next = 1'b1;
        request_next = '0;
        request_next.index = addr_reg[3:0];
        request_next.write_data = muxed_addr_data_bus_in;

        if (host_ctrl.address_latch_strobe) begin
            addr_next = muxed_addr_data_bus_in;
        end

        if (write_edge && writable) begin
            if (addr_reg[3:0] == host_port_pkg::MAP_REG_INDEX) begin
                // Later writes fall through silently
                if (!mapped_reg) begin
                    base_next = muxed_addr_data_bus_in[7:4];
                    mapped_next = 1'b1;
                end
            end else if (addr_reg[3:0] == host_port_pkg::PORTZ_CTRL_INDEX) begin
                portz_ctrl_next = muxed_addr_data_bus_in;
            end else begin
                request_next.write_pulse = 1'b1;
            end
        end

        if (read_active) begin
            bus_oe_n_next = 1'b0;
            if (addr_reg[3:0] == host_port_pkg::PORTZ_CTRL_INDEX) begin
                bus_out_next = portz_ctrl_reg;
            end else begin
                bus_out_next = reg_read_data;
            end
        end

        chain_out_next = mapped_next;

        irq_n_next = !(portz_ctrl_next[host_port_pkg::PORTZ_IRQ_MODE_BIT] && irq_pending);
        if (portz_ctrl_next[host_port_pkg::PORTZ_IRQ_MODE_BIT]) begin
            // Open-drain request: pull low or release
            pin_out_next = 1'b0;
            pin_oe_n_next = irq_n_next;
        end else begin
            pin_out_next = portz_bit7_out;
            pin_oe_n_next = portz_bit7_oe_n;
        end

        // Chain reset overrides everything but the strobe history, including a write in progress
        if (!chain_reset_in) begin
            addr_next = host_port_pkg::ADDR_RESET;
            base_next = host_port_pkg::BASE_RESET;
            mapped_next = 1'b0;
            portz_ctrl_next = host_port_pkg::PORTZ_CTRL_RESET;
            bus_out_next = host_port_pkg::DATA_ZERO;
            bus_oe_n_next = 1'b1;
            request_next = '0;
            chain_out_next = 1'b0;
            irq_n_next = 1'b1;
            pin_out_next = 1'b0;
            pin_oe_n_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // One clock for every flop: the timing clock input
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_reg <= host_port_pkg::ADDR_RESET;
            strobe_prev_reg <= 1'b0;
            base_reg <= host_port_pkg::BASE_RESET;
            mapped_reg <= 1'b0;
            chain_out_reg <= 1'b0;
            portz_ctrl_reg <= host_port_pkg::PORTZ_CTRL_RESET;
            bus_out_reg <= host_port_pkg::DATA_ZERO;
            bus_oe_n_reg <= 1'b1;
            irq_n_reg <= 1'b1;
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
            request_reg <= '0;
        end else begin
            addr_reg <= addr_next;
            strobe_prev_reg <= strobe_prev_next;
            base_reg <= base_next;
            mapped_reg <= mapped_next;
            chain_out_reg <= chain_out_next;
            portz_ctrl_reg <= portz_ctrl_next;
            bus_out_reg <= bus_out_next;
            bus_oe_n_reg <= bus_oe_n_next;
            irq_n_reg <= irq_n_next;
            pin_out_reg <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
            request_reg <= request_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign muxed_addr_data_bus_out = bus_out_reg;
    assign muxed_addr_data_bus_oe_n = bus_oe_n_reg;
    assign chain_reset_out = chain_out_reg;
    assign irq_request_n = irq_n_reg;
    assign irq_or_portz_bit7_pin_out = pin_out_reg;
    assign irq_or_portz_bit7_pin_oe_n = pin_oe_n_reg;
    assign portz_control = portz_ctrl_reg;
    assign base_nibble = base_reg;
    assign mapped = mapped_reg;
    assign reg_request = request_reg;

endmodule

/* verification/host_port_properties.sv */
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module host_port_properties #(
    parameter int IRQ_COUNT = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire host_port_pkg::host_ctrl_type host_ctrl,
    input wire logic [7:0] muxed_addr_data_bus_in,
    input wire logic muxed_addr_data_bus_oe_n,
    input wire logic chain_reset_in,
    input wire logic chain_reset_out,
    input wire logic [IRQ_COUNT-1:0] irq_flag,
    input wire logic [IRQ_COUNT-1:0] irq_enable_bit,
    input wire logic irq_or_portz_bit7_pin_oe_n,
    input wire logic irq_request_n,
    input wire logic [7:0] portz_control,
    input wire logic [3:0] base_nibble,
    input wire logic mapped,
    input wire host_port_pkg::reg_request_type reg_request
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    chain_clear_a: assert property (!chain_reset_in |=>
        !chain_reset_out && !mapped && portz_control == 8'h00) else $error("chain clear");
    chain_rise_a: assert property ($rose(chain_reset_out) |->
        mapped && $past(chain_reset_in)) else $error("chain rise");
    // Skipped after a chain reset cycle, where the request is forced idle
    // Mode bit counts from the edge that writes it, so the current value applies
    irq_follow_a: assert property ($past(chain_reset_in) |-> irq_request_n ==
        !(portz_control[7] && |$past(irq_flag & irq_enable_bit))) else $error("irq");
    pin_irq_a: assert property (!irq_request_n |->
        !irq_or_portz_bit7_pin_oe_n) else $error("pin irq");
    base_hold_a: assert property (mapped && chain_reset_in |=>
        $stable(base_nibble)) else $error("base hold");
    map_capture_a: assert property ($rose(mapped) |->
        base_nibble == $past(muxed_addr_data_bus_in[7:4])) else $error("map capture");
    read_drive_a: assert property (!muxed_addr_data_bus_oe_n |->
        $past(host_ctrl.data_strobe && host_ctrl.read_select)) else $error("read drive");
    write_pulse_a: assert property (reg_request.write_pulse |-> mapped &&
        !$past(host_ctrl.read_select) && reg_request.index != 4'hB) else $error("pulse");
    pulse_once_a: assert property (reg_request.write_pulse |=>
        !reg_request.write_pulse) else $error("pulse once");
    cover property ($rose(mapped));
    cover property (!muxed_addr_data_bus_oe_n);
    cover property (!irq_request_n);
endmodule
bind muxed_bus_host_port host_port_properties #(.IRQ_COUNT(IRQ_COUNT)) i_props (
    .clock, .rst, .host_ctrl, .muxed_addr_data_bus_in, .muxed_addr_data_bus_oe_n,
    .chain_reset_in, .chain_reset_out, .irq_flag, .irq_enable_bit,
    .irq_or_portz_bit7_pin_oe_n, .irq_request_n, .portz_control, .base_nibble,
    .mapped, .reg_request
);

/* verification/host_cpu_model.sv */
// Host CPU model on the multiplexed address/data bus
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clock,
    input wire logic [7:0] bus_in,
    input wire logic bus_oe_n,
    output host_port_pkg::host_ctrl_type host_ctrl,
    output logic [7:0] bus_drive
);
    // ----------------------------------------
    // Bus cycle
    // ----------------------------------------
    initial begin
        host_ctrl = '0;
        bus_drive = 8'h00;
    end
    task automatic access(input logic [7:0] addr, input logic [7:0] wdata,
            input logic rd, output logic [7:0] rdata);
        rdata = 8'h00;
        @(posedge clock);
        host_ctrl <= '{1'h1, 1'h0, rd};
        bus_drive <= addr;
        @(posedge clock);
        host_ctrl <= '{1'h0, 1'h1, rd};
        // Released on reads: the inverse keeps a stale value from passing
        bus_drive <= rd ? ~addr : wdata;
        repeat (3) begin
            @(posedge clock);
            // Last strobe edge wins: a silent unit leaves the inverted address
            if (rd) begin
                rdata = bus_in;
            end
        end
        host_ctrl <= '0;
        bus_drive <= ~bus_drive;
        repeat (2) @(posedge clock);
    endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the multiplexed bus host port
`timescale 1ns/1ps
module testbench;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic chain_reset_in = 1'h1;
    logic [3:0] irq_flag = 4'h0;
    logic [3:0] irq_enable_bit = 4'h0;
    logic portz_bit7_out = 1'h0;
    logic portz_bit7_oe_n = 1'h1;
    logic [7:0] reg_read_data = 8'h00;
    host_port_pkg::host_ctrl_type host_ctrl;
    logic [7:0] bus_in, bus_out, cpu_bus, rv, portz_control;
    logic oe_n, chain_reset_out, pin_out, pin_oe_n, irq_request_n, mapped;
    logic [3:0] base_nibble;
    host_port_pkg::reg_request_type reg_request, last_req;
    int failures = 0;
    int tests_run = 0;
    int pulses = 0;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    always #5 clock = ~clock;
    assign bus_in = oe_n ? cpu_bus : bus_out;
    always @(posedge clock) begin
        if (reg_request.write_pulse === 1'h1) begin
            pulses <= pulses + 1;
            last_req <= reg_request;
        end
    end
    muxed_bus_host_port #(.IRQ_COUNT(4)) i_muxed_bus_host_port (
        .clock, .rst, .host_ctrl, .muxed_addr_data_bus_in(bus_in),
        .muxed_addr_data_bus_out(bus_out), .muxed_addr_data_bus_oe_n(oe_n),
        .chain_reset_in, .chain_reset_out, .irq_flag, .irq_enable_bit,
        .portz_bit7_out, .portz_bit7_oe_n, .irq_or_portz_bit7_pin_out(pin_out),
        .irq_or_portz_bit7_pin_oe_n(pin_oe_n), .irq_request_n, .portz_control,
        .base_nibble, .mapped, .reg_request, .reg_read_data
    );
    host_cpu_model cpu (.clock, .bus_in, .bus_oe_n(oe_n), .host_ctrl, .bus_drive(cpu_bus));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        cpu.access(addr, data, 1'h0, rv);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_mapping;
        wr(8'h07, 8'h80);
        check(portz_control, 8'h00);
        check({7'h00, chain_reset_out}, 8'h00);
        wr(8'hFF, 8'h30);
        check({base_nibble, 2'h0, mapped, chain_reset_out}, 8'h33);
        wr(8'h3F, 8'h50);
        check({4'h0, base_nibble}, 8'h03);
    endtask
    task automatic sc_registers;
        wr(8'h57, 8'h80);
        check(portz_control, 8'h00);
        wr(8'h37, 8'h80);
        check(portz_control, 8'h80);
        cpu.access(8'h37, 8'h00, 1'h1, rv);
        check(rv, 8'h80);
        cpu.access(8'h3F, 8'h00, 1'h1, rv);
        check(rv, 8'hC0);
        cpu.access(8'h52, 8'h00, 1'h1, rv);
        check(rv, 8'hAD);
        reg_read_data <= 8'hC5;
        cpu.access(8'h32, 8'h00, 1'h1, rv);
        check(rv, 8'hC5);
        wr(8'h3B, 8'h11);
        check(pulses[7:0], 8'h00);
        wr(8'h32, 8'hA6);
        check(pulses[7:0], 8'h01);
        check({last_req.index, 4'h0}, 8'h20);
        check(last_req.write_data, 8'hA6);
    endtask
    task automatic sc_interrupt;
        irq_flag <= 4'h4;
        irq_enable_bit <= 4'h4;
        repeat (3) @(posedge clock);
        check({6'h00, irq_request_n, pin_oe_n}, 8'h00);
        irq_enable_bit <= 4'h3;
        repeat (3) @(posedge clock);
        check({7'h00, irq_request_n}, 8'h01);
        portz_bit7_out <= 1'h1;
        portz_bit7_oe_n <= 1'h0;
        irq_enable_bit <= 4'h4;
        wr(8'h37, 8'h00);
        check({5'h00, irq_request_n, pin_out, pin_oe_n}, 8'h06);
    endtask
    task automatic sc_chain;
        wr(8'h37, 8'h40);
        chain_reset_in <= 1'h0;
        repeat (2) @(posedge clock);
        check({mapped, chain_reset_out, 6'h00}, 8'h00);
        check(portz_control, 8'h00);
        wr(8'hFF, 8'h50);
        check({7'h00, mapped}, 8'h00);
        chain_reset_in <= 1'h1;
        repeat (4) @(posedge clock);
        check({7'h00, chain_reset_out}, 8'h00);
        wr(8'hFF, 8'h50);
        check({base_nibble, 2'h0, mapped, chain_reset_out}, 8'h53);
        wr(8'h57, 8'h80);
        check(portz_control, 8'h80);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        @(posedge clock);
        sc_mapping();
        sc_registers();
        sc_interrupt();
        sc_chain();
        report_and_stop();
    end
    // Whole run is about 130 cycles
    initial begin
        #20000;
        failures++;
        report_and_stop();
    end
endmodule
